// ==== core/mcx_map.svh ====
`ifndef MCX_MAP_SVH
`define MCX_MAP_SVH

// ****************************************************************
// widths
// ****************************************************************
`define MCX_INSTR_W 16
`define MCX_DATA_W 16
`define MCX_PC_W 10
`define MCX_SPI_ADDR_W 10
`define MCX_ALU_SEL_W 3
`define MCX_ALU_REGS 8
`define MCX_ROWS 5
`define MCX_ROW_IDX_W 3
`define MCX_COND_SEL_W 4
`define MCX_CONDS 16

// ****************************************************************
// instruction fields and opcodes
// ****************************************************************
`define MCX_INSTR_MSB 15
`define MCX_WAIT_OPC_LSB 5
`define MCX_WAIT_SEL_MSB 4
`define MCX_WAIT_SEL_LSB 0
`define MCX_WAIT_OPC 11'h1A8
`define MCX_WRSPI_OPC 16'h3543
`define MCX_XOR_OPC_LSB 3
`define MCX_XOR_SEL_MSB 2
`define MCX_XOR_SEL_LSB 0
`define MCX_XOR_OPC 13'h05DA

// ****************************************************************
// values
// ****************************************************************
`define MCX_ROWS_NONE 5'h00
`define MCX_DATA_ZERO 16'h0000
`define MCX_DATA_ONES 16'hFFFF
`define MCX_PC_RESET 10'h000
`define MCX_PC_STEP 10'h001
`define MCX_ADDR_RESET 10'h000
`define MCX_COND_RESET 4'h0
`define MCX_DEST_RESET 10'h000

`endif

// ==== core/mcx_pkg.sv ====
`include "mcx_map.svh"

package mcx_pkg;

  typedef enum logic [1:0] {
    MCX_OP_NONE = 2'b00,
    MCX_OP_WAIT = 2'b01,
    MCX_OP_WRSPI = 2'b10,
    MCX_OP_XOR = 2'b11
  } mcx_op_t;

  typedef enum logic {
    MCX_SPI_IDLE = 1'b0,
    MCX_SPI_DATA = 1'b1
  } mcx_spi_state_t;

  typedef logic [`MCX_DATA_W-1:0] mcx_word_t;
  typedef logic [`MCX_PC_W-1:0] mcx_pc_t;
  typedef logic [`MCX_SPI_ADDR_W-1:0] mcx_spi_addr_t;
  typedef logic [`MCX_ALU_SEL_W-1:0] mcx_alu_sel_t;
  typedef logic [`MCX_ROWS-1:0] mcx_rows_t;
  typedef logic [`MCX_ROW_IDX_W-1:0] mcx_row_idx_t;
  typedef logic [`MCX_COND_SEL_W-1:0] mcx_cond_sel_t;
  typedef logic [`MCX_CONDS-1:0] mcx_conds_t;
  typedef logic [`MCX_ALU_REGS-1:0][`MCX_DATA_W-1:0] mcx_alu_file_t;

endpackage : mcx_pkg

// ==== core/mcx_wait_table.sv ====
`include "mcx_map.svh"

module mcx_wait_table (
  input wire logic clock,
  input wire logic rst,
  input wire logic clockEn,
  input wire logic entryWe,
  input wire mcx_pkg::mcx_row_idx_t entryRow,
  input wire mcx_pkg::mcx_cond_sel_t entryCond,
  input wire mcx_pkg::mcx_pc_t entryDest,
  input wire mcx_pkg::mcx_conds_t condIn,
  input wire mcx_pkg::mcx_rows_t rowSelect,
  output logic hit,
  output mcx_pkg::mcx_pc_t hitDest
);
  import mcx_pkg::*;

  mcx_cond_sel_t condSel_q [`MCX_ROWS];
  mcx_pc_t dest_q [`MCX_ROWS];
  mcx_rows_t rowMet;

  // ****************************************************************
  // table rows
  // ****************************************************************
  genvar r;
  generate
    for (r = 0; r < `MCX_ROWS; r++) begin : g_row
      mcx_cond_sel_t condSel_d;
      mcx_pc_t dest_d;
      always_comb begin
        condSel_d = condSel_q[r];
        dest_d = dest_q[r];
        if (entryWe && entryRow == mcx_row_idx_t'(r)) begin // RQ12
          condSel_d = entryCond;
          dest_d = entryDest;
        end
        rowMet[r] = rowSelect[r] & condIn[condSel_q[r]]; // RQ2
      end
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          condSel_q[r] <= `MCX_COND_RESET;
          dest_q[r] <= `MCX_DEST_RESET;
        end else if (clockEn) begin
          condSel_q[r] <= condSel_d;
          dest_q[r] <= dest_d;
        end
      end
    end
  endgenerate

  // lowest satisfied row wins
  always_comb begin
    hit = |rowMet; // RQ2
    hitDest = `MCX_DEST_RESET;
    for (int i = `MCX_ROWS - 1; i >= 0; i--) begin
      if (rowMet[i]) begin
        hitDest = dest_q[i]; // RQ14
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_row0_first;
    rowMet[0] |-> hitDest == dest_q[0];
  endproperty
  a_row0_first: assert property (p_row0_first) // RQ14
    else $error("row one did not take priority");

  property p_none_selected;
    rowSelect == `MCX_ROWS_NONE |-> !hit;
  endproperty
  a_none_selected: assert property (p_none_selected) // RQ1
    else $error("hit with no row enabled");

endmodule : mcx_wait_table

// ==== core/mcx_exec.sv ====
// Operation
// RQ1 - empty row select stalls forever
// RQ2 - each select bit enables one row
// RQ3 - wait opcode upper eleven bits, select low
// RQ4 - spi write uses address and data registers
// RQ5 - program loads those registers beforehand
// RQ6 - spi write completes in two cycles
// RQ7 - changing data next instruction corrupts write
// RQ8 - xor with immediate mask, written back
// RQ9 - zero flag on all-zero xor result
// RQ10 - ones flag on all-ones xor result
// RQ11 - wait holds counter then jumps
// RQ12 - wait table written by entry port
// RQ13 - xor opcode upper thirteen bits, reg low
// RQ14 - lowest satisfied row picks destination
`include "mcx_map.svh"

module mcx_exec (
  input wire logic clock,
  input wire logic rst,
  input wire logic clockEn,
  input wire logic instrValid,
  input wire mcx_pkg::mcx_word_t instrWord,
  input wire mcx_pkg::mcx_conds_t waitCondIn,
  input wire logic waitEntryWe,
  input wire mcx_pkg::mcx_row_idx_t waitEntryRow,
  input wire mcx_pkg::mcx_cond_sel_t waitEntryCond,
  input wire mcx_pkg::mcx_pc_t waitEntryDest,
  input wire mcx_pkg::mcx_spi_addr_t serialAddrReg,
  input wire mcx_pkg::mcx_word_t serialDataReg,
  input wire mcx_pkg::mcx_word_t immediateMaskReg,
  input wire logic aluWrEn,
  input wire mcx_pkg::mcx_alu_sel_t aluWrSel,
  input wire mcx_pkg::mcx_word_t aluWrData,
  output mcx_pkg::mcx_pc_t microcodeProgramCounter_q,
  output logic waitStall_q,
  output logic spiWrBusy_q,
  output logic spiWrStrobe_q,
  output mcx_pkg::mcx_spi_addr_t spiWrAddr_q,
  output mcx_pkg::mcx_word_t spiWrData_q,
  output mcx_pkg::mcx_alu_file_t aluRegisterSubset_q,
  output logic maskZeroFlag_q,
  output logic maskOnesFlag_q
);
  import mcx_pkg::*;

  // ****************************************************************
  // decode
  // ****************************************************************
  mcx_op_t opKind;
  mcx_rows_t waitRowSelect;
  mcx_alu_sel_t aluOperandSelect;

  always_comb begin
    opKind = MCX_OP_NONE;
    waitRowSelect = instrWord[`MCX_WAIT_SEL_MSB:`MCX_WAIT_SEL_LSB]; // RQ3
    aluOperandSelect = instrWord[`MCX_XOR_SEL_MSB:`MCX_XOR_SEL_LSB]; // RQ13
    if (instrValid) begin
      if (instrWord[`MCX_INSTR_MSB:`MCX_WAIT_OPC_LSB] == `MCX_WAIT_OPC) begin
        opKind = MCX_OP_WAIT; // RQ3
      end else if (instrWord == `MCX_WRSPI_OPC) begin
        opKind = MCX_OP_WRSPI;
      end else if (instrWord[`MCX_INSTR_MSB:`MCX_XOR_OPC_LSB]
                   == `MCX_XOR_OPC) begin
        opKind = MCX_OP_XOR; // RQ13
      end
    end
  end

  logic waitHit;
  mcx_pc_t waitDest;

  mcx_wait_table u_wait_table (
    .clock(clock),
    .rst(rst),
    .clockEn(clockEn),
    .entryWe(waitEntryWe),
    .entryRow(waitEntryRow),
    .entryCond(waitEntryCond),
    .entryDest(waitEntryDest),
    .condIn(waitCondIn),
    .rowSelect(waitRowSelect),
    .hit(waitHit),
    .hitDest(waitDest)
  );

  // ****************************************************************
  // program counter
  // ****************************************************************
  mcx_pc_t pc_d;
  logic waitStall_d;

  always_comb begin
    pc_d = microcodeProgramCounter_q;
    waitStall_d = 1'b0;
    case (opKind)
      MCX_OP_WAIT: begin
        if (waitRowSelect == `MCX_ROWS_NONE) begin
          waitStall_d = 1'b1; // RQ1
        end else if (waitHit) begin
          pc_d = waitDest; // RQ11
        end else begin
          waitStall_d = 1'b1; // RQ11
        end
      end
      MCX_OP_WRSPI: begin
        if (!spiWrBusy_q) begin
          pc_d = microcodeProgramCounter_q + `MCX_PC_STEP;
        end
      end
      MCX_OP_XOR: begin
        pc_d = microcodeProgramCounter_q + `MCX_PC_STEP;
      end
      MCX_OP_NONE: begin
        if (instrValid) begin
          pc_d = microcodeProgramCounter_q + `MCX_PC_STEP;
        end
      end
      default: begin
        pc_d = microcodeProgramCounter_q;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      microcodeProgramCounter_q <= `MCX_PC_RESET;
      waitStall_q <= 1'b0;
    end else if (clockEn) begin
      microcodeProgramCounter_q <= pc_d;
      waitStall_q <= waitStall_d;
    end
  end

  // ****************************************************************
  // spi backdoor write
  // ****************************************************************
  mcx_spi_state_t spiState_q, spiState_d;
  logic spiWrBusy_d;
  logic spiWrStrobe_d;
  mcx_spi_addr_t spiWrAddr_d;
  mcx_word_t spiWrData_d;

  always_comb begin
    spiState_d = spiState_q;
    spiWrBusy_d = spiWrBusy_q;
    spiWrStrobe_d = 1'b0;
    spiWrAddr_d = spiWrAddr_q;
    spiWrData_d = spiWrData_q;
    case (spiState_q)
      MCX_SPI_IDLE: begin
        if (opKind == MCX_OP_WRSPI) begin
          spiState_d = MCX_SPI_DATA;
          spiWrBusy_d = 1'b1;
          spiWrAddr_d = serialAddrReg; // RQ4
        end
      end
      MCX_SPI_DATA: begin
        // data taken one cycle late, overlapping the next instruction
        spiWrData_d = serialDataReg; // RQ7
        spiWrStrobe_d = 1'b1; // RQ6
        spiWrBusy_d = 1'b0;
        spiState_d = MCX_SPI_IDLE;
      end
      default: begin
        spiState_d = MCX_SPI_IDLE;
        spiWrBusy_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      spiState_q <= MCX_SPI_IDLE;
      spiWrBusy_q <= 1'b0;
      spiWrStrobe_q <= 1'b0;
      spiWrAddr_q <= `MCX_ADDR_RESET;
      spiWrData_q <= `MCX_DATA_ZERO;
    end else if (clockEn) begin
      spiState_q <= spiState_d;
      spiWrBusy_q <= spiWrBusy_d;
      spiWrStrobe_q <= spiWrStrobe_d;
      spiWrAddr_q <= spiWrAddr_d;
      spiWrData_q <= spiWrData_d;
    end
  end

  // ****************************************************************
  // alu registers and mask flags
  // ****************************************************************
  mcx_alu_file_t aluRegs_d;
  mcx_word_t xorResult;
  logic maskZeroFlag_d;
  logic maskOnesFlag_d;

  always_comb begin
    aluRegs_d = aluRegisterSubset_q;
    maskZeroFlag_d = maskZeroFlag_q;
    maskOnesFlag_d = maskOnesFlag_q;
    xorResult = aluRegisterSubset_q[aluOperandSelect] ^ immediateMaskReg;
    if (aluWrEn) begin
      aluRegs_d[aluWrSel] = aluWrData;
    end
    if (opKind == MCX_OP_XOR) begin
      aluRegs_d[aluOperandSelect] = xorResult; // RQ8
      maskZeroFlag_d = (xorResult == `MCX_DATA_ZERO); // RQ9
      maskOnesFlag_d = (xorResult == `MCX_DATA_ONES); // RQ10
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aluRegisterSubset_q <= '0;
      maskZeroFlag_q <= 1'b0;
      maskOnesFlag_q <= 1'b0;
    end else if (clockEn) begin
      aluRegisterSubset_q <= aluRegs_d;
      maskZeroFlag_q <= maskZeroFlag_d;
      maskOnesFlag_q <= maskOnesFlag_d;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic rawWait;
  logic rawXor;
  assign rawWait = instrValid
    && instrWord[`MCX_INSTR_MSB:`MCX_WAIT_OPC_LSB] == `MCX_WAIT_OPC;
  assign rawXor = instrValid && !rawWait && instrWord != `MCX_WRSPI_OPC
    && instrWord[`MCX_INSTR_MSB:`MCX_XOR_OPC_LSB] == `MCX_XOR_OPC;

  property p_wait_forever;
    clockEn && rawWait
      && instrWord[`MCX_WAIT_SEL_MSB:`MCX_WAIT_SEL_LSB] == '0
      |=> waitStall_q && $stable(microcodeProgramCounter_q);
  endproperty
  a_wait_forever: assert property (p_wait_forever) // RQ1
    else $error("empty wait select did not stall");

  property p_wait_jump;
    clockEn && rawWait && waitHit
      |=> microcodeProgramCounter_q == $past(waitDest) && !waitStall_q;
  endproperty
  a_wait_jump: assert property (p_wait_jump) // RQ11
    else $error("wait did not jump to row destination");

  property p_wait_hold;
    clockEn && rawWait && !waitHit |=> $stable(microcodeProgramCounter_q);
  endproperty
  a_wait_hold: assert property (p_wait_hold) // RQ11
    else $error("program counter moved during unmet wait");

  sequence s_spi_start;
    clockEn && opKind == MCX_OP_WRSPI && !spiWrBusy_q ##1 clockEn;
  endsequence

  property p_spi_two;
    s_spi_start |-> spiWrBusy_q && !spiWrStrobe_q
      ##1 spiWrStrobe_q && !spiWrBusy_q;
  endproperty
  a_spi_two: assert property (p_spi_two) // RQ6
    else $error("spi write not done in two cycles");

  property p_spi_addr;
    clockEn && opKind == MCX_OP_WRSPI && !spiWrBusy_q
      |=> spiWrAddr_q == $past(serialAddrReg);
  endproperty
  a_spi_addr: assert property (p_spi_addr) // RQ4
    else $error("spi write address not taken from register");

  property p_spi_data;
    $rose(spiWrStrobe_q) |-> spiWrData_q == $past(serialDataReg);
  endproperty
  a_spi_data: assert property (p_spi_data) // RQ7
    else $error("spi write data not from second cycle");

  property p_xor_result;
    clockEn && rawXor && !aluWrEn |=>
      aluRegisterSubset_q[$past(
        instrWord[`MCX_XOR_SEL_MSB:`MCX_XOR_SEL_LSB])]
      == $past(xorResult);
  endproperty
  a_xor_result: assert property (p_xor_result) // RQ8
    else $error("xor result not written back");

  property p_mask_zero;
    clockEn && rawXor |=> maskZeroFlag_q == ($past(xorResult) == '0);
  endproperty
  a_mask_zero: assert property (p_mask_zero) // RQ9
    else $error("zero flag wrong after xor");

  property p_mask_ones;
    clockEn && rawXor |=> maskOnesFlag_q == (&$past(xorResult));
  endproperty
  a_mask_ones: assert property (p_mask_ones) // RQ10
    else $error("ones flag wrong after xor");

  c_wait_jump: cover property (clockEn && rawWait && waitHit);
  c_wait_forever: cover property (waitStall_q [*4]);
  c_spi_strobe: cover property (s_spi_start ##1 spiWrStrobe_q);
  c_xor_zero: cover property (clockEn && rawXor ##1 maskZeroFlag_q);

endmodule : mcx_exec

// ==== test/mcx_spi_sink.sv ====
module mcx_spi_sink (
  input wire logic clock,
  input wire logic rst,
  input wire logic spiWrStrobe,
  input wire mcx_pkg::mcx_spi_addr_t spiWrAddr,
  input wire mcx_pkg::mcx_word_t spiWrData,
  output mcx_pkg::mcx_spi_addr_t lastAddr_q,
  output mcx_pkg::mcx_word_t lastData_q,
  output logic [7:0] writeCount_q
);
  timeunit 1ns;
  timeprecision 1ns;
  import mcx_pkg::*;
  mcx_spi_addr_t lastAddr_d;
  mcx_word_t lastData_d;
  logic [7:0] writeCount_d;
  // backdoor target keeps whatever arrives with the strobe
  always_comb begin
    lastAddr_d = lastAddr_q;
    lastData_d = lastData_q;
    writeCount_d = writeCount_q;
    if (spiWrStrobe) begin
      lastAddr_d = spiWrAddr;
      lastData_d = spiWrData;
      writeCount_d = writeCount_q + 8'h01;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lastAddr_q <= 10'h000;
      lastData_q <= 16'h0000;
      writeCount_q <= 8'h00;
    end else begin
      lastAddr_q <= lastAddr_d;
      lastData_q <= lastData_d;
      writeCount_q <= writeCount_d;
    end
  end
endmodule : mcx_spi_sink

// ==== test/testbench.sv ====
`include "mcx_map.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import mcx_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic clockEn = 1'b1;
  logic instrValid = 1'b0;
  mcx_word_t instrWord = 16'h0000;
  mcx_conds_t waitCondIn = 16'h0000;
  logic entryWe = 1'b0;
  mcx_row_idx_t entryRow = 3'h0;
  mcx_cond_sel_t entryCond = 4'h0;
  mcx_pc_t entryDest = 10'h000;
  mcx_spi_addr_t serAddr = 10'h000;
  mcx_word_t serData = 16'h0000;
  mcx_word_t imm = 16'h0000;
  logic aluWrEn = 1'b0;
  mcx_alu_sel_t aluWrSel = 3'h0;
  mcx_word_t aluWrData = 16'h0000;
  mcx_pc_t pc, expPc;
  logic stall, busy, strobe, zeroFlag, onesFlag;
  mcx_spi_addr_t wrAddr, sinkAddr;
  mcx_word_t wrData, sinkData, e;
  mcx_alu_file_t alu;
  logic [7:0] sinkCount;
  logic [4:0] m;
  mcx_word_t imms[3] = '{16'h1234, 16'hFFFF, 16'h00F0};
  int fails = 0;
  int check_count = 0;

  mcx_exec u_mcx_exec (.clock(clock), .rst(rst), .clockEn(clockEn),
    .instrValid(instrValid), .instrWord(instrWord),
    .waitCondIn(waitCondIn), .waitEntryWe(entryWe),
    .waitEntryRow(entryRow), .waitEntryCond(entryCond),
    .waitEntryDest(entryDest), .serialAddrReg(serAddr),
    .serialDataReg(serData), .immediateMaskReg(imm),
    .aluWrEn(aluWrEn), .aluWrSel(aluWrSel), .aluWrData(aluWrData),
    .microcodeProgramCounter_q(pc), .waitStall_q(stall),
    .spiWrBusy_q(busy), .spiWrStrobe_q(strobe), .spiWrAddr_q(wrAddr),
    .spiWrData_q(wrData), .aluRegisterSubset_q(alu),
    .maskZeroFlag_q(zeroFlag), .maskOnesFlag_q(onesFlag));
  mcx_spi_sink u_mcx_spi_sink (.clock(clock), .rst(rst),
    .spiWrStrobe(strobe), .spiWrAddr(wrAddr), .spiWrData(wrData),
    .lastAddr_q(sinkAddr), .lastData_q(sinkData),
    .writeCount_q(sinkCount));

  always #10 clock = ~clock;

  // ****************************************************************
  // tasks
  // ****************************************************************
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one word held valid for n consecutive cycles
  task run(input mcx_word_t w, input int n);
    @(posedge clock);
    instrWord <= w;
    instrValid <= 1'b1;
    repeat (n) @(posedge clock);
    instrValid <= 1'b0;
    #1;
  endtask : run

  // data changed under the busy cycle is the data that gets written
  task spi(input mcx_spi_addr_t a, input mcx_word_t d, input mcx_word_t nd);
    @(posedge clock);
    serAddr <= a;
    serData <= d;
    instrWord <= `MCX_WRSPI_OPC;
    instrValid <= 1'b1;
    @(posedge clock);
    instrValid <= 1'b0;
    serAddr <= ~a;
    serData <= nd;
    #1;
    expPc++;
    chk(busy, 1'b1);
    @(posedge clock);
    #1;
    chk(strobe, 1'b1);
    chk(busy, 1'b0);
    chk(wrAddr, a);
    chk(wrData, nd);
    chk(pc, expPc);
    @(posedge clock);
    #1;
    chk(strobe, 1'b0);
    chk(sinkAddr, a);
    chk(sinkData, nd);
  endtask : spi

  task summarize;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    #200000;
    fails++;
    summarize();
  end

  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      @(posedge clock);
      entryWe <= 1'b1;
      entryRow <= 3'(i);
      entryCond <= 4'(i * 3);
      entryDest <= 10'(10'h100 + i * 16);
    end
    @(posedge clock);
    entryWe <= 1'b0;
    waitCondIn <= 16'h0208;
    expPc = 10'h000;
    for (int i = 0; i < 32; i++) begin
      m = 5'(i);
      run({`MCX_WAIT_OPC, m}, 1);
      if (m[1]) expPc = 10'h110;
      else if (m[3]) expPc = 10'h130;
      chk(pc, expPc);
      chk(stall, !(m[1] | m[3]));
    end
    @(posedge clock);
    waitCondIn <= 16'h0001;
    run({`MCX_WAIT_OPC, 5'h01}, 1);
    expPc = 10'h100;
    chk(pc, expPc);
    run(16'h3521, 1);
    expPc++;
    chk(pc, expPc);
    @(posedge clock);
    aluWrEn <= 1'b1;
    aluWrSel <= 3'h2;
    aluWrData <= 16'h1234;
    e = 16'h1234;
    foreach (imms[k]) begin
      @(posedge clock);
      aluWrEn <= 1'b0;
      imm <= imms[k];
      run({`MCX_XOR_OPC, 3'h2}, 1);
      e = e ^ imms[k];
      expPc++;
      chk(alu[2], e);
      chk(zeroFlag, e == 16'h0000);
      chk(onesFlag, e == 16'hFFFF);
      chk(pc, expPc);
    end
    @(posedge clock);
    clockEn <= 1'b0;
    run({`MCX_XOR_OPC, 3'h2}, 3);
    chk(alu[2], e);
    chk(onesFlag, 1'b0);
    chk(pc, expPc);
    @(posedge clock);
    clockEn <= 1'b1;
    spi(10'h2A5, 16'hBEEF, 16'hBEEF);
    spi(10'h15A, 16'h1234, 16'h0BAD);
    run(`MCX_WRSPI_OPC, 3);
    expPc = expPc + 10'h002;
    chk(busy, 1'b1);
    chk(pc, expPc);
    @(posedge clock);
    #1;
    chk(strobe, 1'b1);
    @(posedge clock);
    #1;
    chk(sinkCount, 8'h04);
    summarize();
  end
endmodule : testbench
